// ### rtl/motor_sim_map.svh
// register map, field positions and timing constants of the simulated event compare block
`ifndef MOTOR_SIM_MAP_SVH
`define MOTOR_SIM_MAP_SVH
// register addresses
`define ADDR_DEMAG 4'h0
`define ADDR_ZERO 4'h1
`define ADDR_COMM 4'h2
`define ADDR_CTRL_B 4'h3
`define ADDR_CTRL_C 4'h4
`define ADDR_PRESC 4'h5
`define ADDR_TIMER 4'h6
`define ADDR_STATUS 4'h7
// field positions
`define CTRL_B_SDM 0
`define CTRL_C_SZ 0
`define CTRL_C_SC 1
`define CTRL_C_SWA 2
`define STAT_RPI 0
`define STAT_RMI 1
`define STAT_PH_LO 2
`define STAT_PH_HI 4
// channel indices
`define CH_DEMAG 0
`define CH_ZERO 1
`define CH_COMM 2
`define HW_ARMS 3'h4
// reset values and timer landmarks
`define REG_RST 8'h00
`define RATIO_RST 4'h0
`define TIMER_MAX 8'hFF
`define TIMER_MEDIAN 8'h80
`define TIMER_DEC_THRESH 8'h55
`define RATIO_MAX 4'hF
`define RATIO_MIN 4'h0
// timer tick at code zero, in ns, and the clock period in ns
`define TICK_NS 500
`define CLK_NS 20
`define TICK_CYCLES ((`TICK_NS) / (`CLK_NS))
// range of tick lengths that the 24-bit divider can serve at every ratio code
`define TICK_CYCLES_MIN 1
`define TICK_CYCLES_MAX 511
`endif

// ### rtl/motor_sim_pkg.sv
// types shared by the simulated event compare block
package motor_sim_pkg;
  // expected next event of the electrical step
  typedef enum logic [2:0] {
    PH_WAIT_C = 3'b001,
    PH_WAIT_D = 3'b010,
    PH_WAIT_Z = 3'b100
  } phase_e;
endpackage : motor_sim_pkg

// ### rtl/sim_compare_channel.sv
// one capture/compare register with its arm flag and late-target protection
`timescale 1ns/1ps
`include "motor_sim_map.svh"
module sim_compare_channel #(
  parameter bit HW_ARMS = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // control
  input wire logic enable,
  input wire logic sw_wr,
  input wire logic hw_ld,
  input wire logic disarm,
  input wire logic shr,
  input wire logic shl,
  // data
  input wire logic [7:0] sw_data,
  input wire logic [7:0] hw_data,
  input wire logic [7:0] timer,
  // state
  output logic [7:0] value,
  output logic armed,
  output logic fire
);
  logic fire_now;
  logic arm_now;

  // a late target fires at once because <= is used, not == (see [R3])
  assign arm_now = sw_wr | (hw_ld & HW_ARMS);
  // a disarm in the same cycle wins, so a stale commutation target never fires as simulated commutation is switched on
  assign fire_now = armed & enable & (value <= timer)
    & ~sw_wr & ~hw_ld & ~disarm; // see [R1] see [R11]

  // arm on a software write or, with HW_ARMS, a hardware load; disarm on the single firing or when a hardware event takes the step (see [R20])
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      armed <= 1'b0;
    end else if (arm_now) begin
      armed <= 1'b1;
    end else if (disarm | fire_now | hw_ld) begin
      armed <= 1'b0;
    end
  end

  // event pulse, one cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fire <= 1'b0;
    end else begin
      fire <= fire_now;
    end
  end

  // value: load, overwrite with the timer on firing, follow prescaler rescaling
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      value <= `REG_RST;
    end else if (sw_wr) begin
      value <= sw_data;
    end else if (hw_ld) begin
      value <= hw_data;
    end else if (fire_now) begin
      value <= timer; // see [R3]
    end else if (shr) begin
      value <= {1'b0, value[7:1]}; // see [R18]
    end else if (shl) begin
      value <= value[7] ? `TIMER_MAX : {value[6:0], 1'b0}; // see [R19]
    end
  end
endmodule : sim_compare_channel

// ### rtl/step_timer_unit.sv
// step timer with the auto-switched step ratio prescaler
`timescale 1ns/1ps
`include "motor_sim_map.svh"
module step_timer_unit #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // control
  input wire logic auto_sw,
  input wire logic zero_evt,
  input wire logic presc_wr,
  input wire logic [3:0] presc_data,
  // state
  output logic [7:0] timer,
  output logic [3:0] ratio,
  output logic shr,
  output logic shl
);
  logic [23:0] cnt;
  logic [23:0] lim;
  logic tick;
  logic up_ok;

  // refuse tick lengths that the divider cannot count at the top ratio code
  if (TICK_CYCLES < `TICK_CYCLES_MIN || TICK_CYCLES > `TICK_CYCLES_MAX) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  // each ratio step doubles the tick period (see [R16])
  assign lim = 24'(TICK_CYCLES) << ratio;
  assign tick = (cnt == lim - 24'h000001);
  assign up_ok = auto_sw & (ratio != `RATIO_MAX);
  assign shr = tick & (timer == `TIMER_MAX) & up_ok; // see [R18]
  assign shl = zero_evt & auto_sw & (timer < `TIMER_DEC_THRESH)
    & (ratio != `RATIO_MIN); // see [R19]

  // tick divider, restarted with the timer
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 24'h000000;
    end else if (zero_evt | tick) begin
      cnt <= 24'h000000;
    end else begin
      cnt <= cnt + 24'h000001;
    end
  end

  // timer: zero crossing resets it, overflow restarts at the median or wraps
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timer <= `REG_RST;
    end else if (zero_evt) begin
      timer <= `REG_RST; // see [R9]
    end else if (tick) begin
      if (timer == `TIMER_MAX) begin
        timer <= up_ok ? `TIMER_MEDIAN : `REG_RST; // see [R18]
      end else begin
        timer <= timer + 8'h01;
      end
    end
  end

  // ratio moves by itself only in auto-switched mode (see [R15])
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ratio <= `RATIO_RST;
    end else if (presc_wr) begin
      ratio <= presc_data;
    end else if (shr) begin
      ratio <= ratio + 4'h1;
    end else if (shl) begin
      ratio <= ratio - 4'h1;
    end
  end

  property p_ratio_up;
    @(posedge mclk) disable iff (!arst_n)
      (tick && auto_sw && timer == `TIMER_MAX && ratio != `RATIO_MAX && !presc_wr)
      |=> (ratio == $past(ratio) + 4'h1)
        && (timer == ($past(zero_evt) ? `REG_RST : `TIMER_MEDIAN)); // zero crossing still wins
  endproperty
  a_ratio_up: assert property (p_ratio_up) else $error("no ratio step up"); // see [R18]

  property p_ratio_down;
    @(posedge mclk) disable iff (!arst_n)
      (zero_evt && auto_sw && timer < `TIMER_DEC_THRESH && ratio != `RATIO_MIN && !presc_wr)
      |=> (ratio == $past(ratio) - 4'h1) && (timer == `REG_RST);
  endproperty
  a_ratio_down: assert property (p_ratio_down) else $error("no ratio step down"); // see [R19]
endmodule : step_timer_unit

// ### rtl/motor_sim_event_compare.sv
// simulated demag, zero-crossing and commutation event compare with built-in checks
//
// Behaviour
// [R1] compare registers are software writable; reaching them raises the matching event
// [R2] each simulated event type has its own enable bit
// [R3] a target at or below the timer fires at once and takes the timer value
// [R4] hardware commutation expects commutation, then demag, then zero crossing
// [R5] software writes the demag target after the preceding commutation
// [R6] software writes the zero-crossing target after the preceding demag
// [R7] simulated commutation ignores the multiplier and drops the fixed order
// [R8] with simulated commutation, commutations may follow without demag between
// [R9] demag and zero crossing still act; zero crossing resets the timer
// [R10] software keeps demag ahead of zero crossing in simulated commutation
// [R11] after enabling simulated commutation, only a commutation write re-arms it
// [R12] software should write the commutation target in the zero-crossing handler
// [R13] two different simulated event types may occur in one step
// [R14] multiplier results are ignored after zero crossings once simulated commutation is on
// [R15] auto-switched mode moves the four-bit ratio field by itself
// [R16] each ratio code doubles the timer tick period
// [R17] software never writes zero as the simulated commutation target
// [R18] overflow in auto mode: ratio up, halve values, plus flag, restart at median
// [R19] fast zero crossing in auto mode: ratio down, double values, minus flag
// [R20] each armed compare is checked every clock and fires once per arming
`timescale 1ns/1ps
`include "motor_sim_map.svh"
module motor_sim_event_compare #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // hardware events and multiplier result
  input wire logic hw_demag,
  input wire logic hw_zero,
  input wire logic mult_load,
  input wire logic [7:0] mult_value,
  // event outputs
  output logic evt_comm,
  output logic evt_demag,
  output logic evt_zero,
  // timer state for the rest of the controller
  output logic [7:0] step_timer,
  output logic [3:0] step_ratio_field
);

  ////////////////////////////////////////////////////////////////////////////
  // control registers and flags

  logic sim_demag_enable;
  logic sim_commutation_enable;
  logic sim_zero_cross_enable;
  logic auto_switch_select;
  logic sc_prev;
  logic ratio_plus_flag;
  logic ratio_minus_flag;
  motor_sim_pkg::phase_e phase;

  // decoded strobes
  logic wr_demag;
  logic wr_zero;
  logic wr_comm;
  logic wr_b;
  logic wr_c;
  logic wr_presc;
  logic wr_stat;
  logic sc_rise;

  // event terms
  logic ev_c;
  logic ev_d;
  logic ev_z;
  logic hw_d_ok;
  logic hw_z_ok;
  logic hw_c_ok;
  logic shr;
  logic shl;

  // channel vectors
  logic [2:0] ch_en;
  logic [2:0] ch_wr;
  logic [2:0] ch_hw;
  logic [2:0] ch_dis;
  logic [2:0] ch_armed;
  logic [2:0] ch_fire;
  logic [7:0] ch_hwdata [3];
  logic [7:0] ch_val [3];

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  assign wr_demag = reg_wr & (reg_addr == `ADDR_DEMAG);
  assign wr_zero = reg_wr & (reg_addr == `ADDR_ZERO);
  // the commutation target belongs to software only in simulated mode
  assign wr_comm = reg_wr & (reg_addr == `ADDR_COMM) & sim_commutation_enable;
  assign wr_b = reg_wr & (reg_addr == `ADDR_CTRL_B);
  assign wr_c = reg_wr & (reg_addr == `ADDR_CTRL_C);
  // ratio is read-only while auto switching runs
  assign wr_presc = reg_wr & (reg_addr == `ADDR_PRESC) & ~auto_switch_select;
  assign wr_stat = reg_wr & (reg_addr == `ADDR_STATUS);

  // control register b
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sim_demag_enable <= 1'b0;
    end else if (wr_b) begin
      sim_demag_enable <= reg_wdata[`CTRL_B_SDM]; // see [R2]
    end
  end

  // control register c
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sim_zero_cross_enable <= 1'b0;
      sim_commutation_enable <= 1'b0;
      auto_switch_select <= 1'b0;
    end else if (wr_c) begin
      sim_zero_cross_enable <= reg_wdata[`CTRL_C_SZ]; // see [R2]
      sim_commutation_enable <= reg_wdata[`CTRL_C_SC]; // see [R2]
      auto_switch_select <= reg_wdata[`CTRL_C_SWA];
    end
  end

  // edge of the simulated commutation enable
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sc_prev <= 1'b0;
    end else begin
      sc_prev <= sim_commutation_enable;
    end
  end

  // setting the bit drops any pending commutation comparison until software writes again
  assign sc_rise = sim_commutation_enable & ~sc_prev; // see [R11]

  ////////////////////////////////////////////////////////////////////////////
  // event sequencing

  // hardware events count only where the sequence expects them
  assign hw_d_ok = hw_demag & (phase == motor_sim_pkg::PH_WAIT_D) & ~sim_demag_enable;
  assign hw_z_ok = hw_zero & (phase == motor_sim_pkg::PH_WAIT_Z) & ~sim_zero_cross_enable;
  // multiplier result is disregarded in simulated commutation mode
  assign hw_c_ok = mult_load & ~sim_commutation_enable; // see [R7] see [R14]

  // each event type has its own channel, so two may share one step (see [R13])
  assign ev_c = ch_fire[`CH_COMM];
  assign ev_d = ch_fire[`CH_DEMAG] | hw_d_ok;
  assign ev_z = ch_fire[`CH_ZERO] | hw_z_ok;

  // channel enables: demag and zero checked at their place in the order
  always_comb begin
    ch_en[`CH_DEMAG] = sim_demag_enable & (phase == motor_sim_pkg::PH_WAIT_D); // see [R4]
    ch_en[`CH_ZERO] = sim_zero_cross_enable & (phase == motor_sim_pkg::PH_WAIT_Z); // see [R4]
    // simulated commutation may fire in any phase (see [R8])
    ch_en[`CH_COMM] = sim_commutation_enable | (phase == motor_sim_pkg::PH_WAIT_C);
  end

  // channel loads: software writes, multiplier result, captures of hardware events
  always_comb begin
    ch_wr[`CH_DEMAG] = wr_demag;
    ch_wr[`CH_ZERO] = wr_zero;
    ch_wr[`CH_COMM] = wr_comm; // see [R11]
    ch_hw[`CH_DEMAG] = hw_d_ok;
    ch_hw[`CH_ZERO] = hw_z_ok;
    ch_hw[`CH_COMM] = hw_c_ok;
    ch_hwdata[`CH_DEMAG] = step_timer;
    ch_hwdata[`CH_ZERO] = step_timer;
    ch_hwdata[`CH_COMM] = mult_value;
    ch_dis = 3'h0;
    ch_dis[`CH_COMM] = sc_rise; // see [R11]
  end

  // phase: C then D then Z; simulated commutation restarts D from anywhere
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= motor_sim_pkg::PH_WAIT_C;
    end else begin
      case (phase)
        motor_sim_pkg::PH_WAIT_C: begin
          if (ev_c) begin
            phase <= motor_sim_pkg::PH_WAIT_D; // see [R4]
          end
        end
        motor_sim_pkg::PH_WAIT_D: begin
          if (ev_c) begin
            phase <= motor_sim_pkg::PH_WAIT_D; // see [R8]
          end else if (ev_d) begin
            phase <= motor_sim_pkg::PH_WAIT_Z;
          end
        end
        motor_sim_pkg::PH_WAIT_Z: begin
          if (ev_c) begin
            phase <= motor_sim_pkg::PH_WAIT_D; // see [R8]
          end else if (ev_z) begin
            phase <= motor_sim_pkg::PH_WAIT_C; // see [R9]
          end
        end
        default: begin
          phase <= motor_sim_pkg::PH_WAIT_C;
        end
      endcase
    end
  end

  // registered event pulses for the rest of the controller
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evt_comm <= 1'b0;
      evt_demag <= 1'b0;
      evt_zero <= 1'b0;
    end else begin
      evt_comm <= ev_c;
      evt_demag <= ev_d;
      evt_zero <= ev_z;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare channels and step timer

  // one channel per compare register, evaluated every clock (see [R20])
  for (genvar i = 0; i < 3; i++) begin : g_ch
    sim_compare_channel #(
      .HW_ARMS(1'(`HW_ARMS >> i))
    ) u_ch (
      .mclk(mclk),
      .arst_n(arst_n),
      .enable(ch_en[i]),
      .sw_wr(ch_wr[i]),
      .hw_ld(ch_hw[i]),
      .disarm(ch_dis[i]),
      .shr(shr),
      .shl(shl),
      .sw_data(reg_wdata),
      .hw_data(ch_hwdata[i]),
      .timer(step_timer),
      .value(ch_val[i]),
      .armed(ch_armed[i]),
      .fire(ch_fire[i])
    );
  end

  // zero crossing of any origin resets the timer (see [R9])
  step_timer_unit #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .arst_n(arst_n),
    .auto_sw(auto_switch_select),
    .zero_evt(ev_z),
    .presc_wr(wr_presc),
    .presc_data(reg_wdata[3:0]),
    .timer(step_timer),
    .ratio(step_ratio_field),
    .shr(shr),
    .shl(shl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // ratio flags and read port

  // sticky ratio flags, write one to clear; a new set beats the clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ratio_plus_flag <= 1'b0;
      ratio_minus_flag <= 1'b0;
    end else begin
      ratio_plus_flag <= shr | (ratio_plus_flag & ~(wr_stat & reg_wdata[`STAT_RPI])); // see [R18]
      ratio_minus_flag <= shl | (ratio_minus_flag & ~(wr_stat & reg_wdata[`STAT_RMI])); // see [R19]
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `REG_RST;
    end else if (!reg_rd) begin
      reg_rdata <= `REG_RST;
    end else begin
      case (reg_addr)
        `ADDR_DEMAG: reg_rdata <= ch_val[`CH_DEMAG];
        `ADDR_ZERO: reg_rdata <= ch_val[`CH_ZERO];
        `ADDR_COMM: reg_rdata <= ch_val[`CH_COMM];
        `ADDR_CTRL_B: begin
          reg_rdata <= `REG_RST;
          reg_rdata[`CTRL_B_SDM] <= sim_demag_enable;
        end
        `ADDR_CTRL_C: begin
          reg_rdata <= `REG_RST;
          reg_rdata[`CTRL_C_SZ] <= sim_zero_cross_enable;
          reg_rdata[`CTRL_C_SC] <= sim_commutation_enable;
          reg_rdata[`CTRL_C_SWA] <= auto_switch_select;
        end
        `ADDR_PRESC: reg_rdata <= {4'h0, step_ratio_field};
        `ADDR_TIMER: reg_rdata <= step_timer;
        `ADDR_STATUS: begin
          reg_rdata <= `REG_RST;
          reg_rdata[`STAT_RPI] <= ratio_plus_flag;
          reg_rdata[`STAT_RMI] <= ratio_minus_flag;
          reg_rdata[`STAT_PH_HI:`STAT_PH_LO] <= phase;
        end
        default: reg_rdata <= `REG_RST;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  sequence s_demag_due;
    ch_armed[`CH_DEMAG] && ch_en[`CH_DEMAG] && ch_val[`CH_DEMAG] <= step_timer
      && !wr_demag && !hw_d_ok;
  endsequence

  sequence s_demag_done;
    ch_fire[`CH_DEMAG] && !ch_armed[`CH_DEMAG];
  endsequence

  property p_demag_fires;
    s_demag_due |=> s_demag_done ##1 !ch_fire[`CH_DEMAG];
  endproperty
  a_demag_fires: assert property (p_demag_fires) else $error("demag target missed"); // see [R1]

  property p_capture_timer;
    ch_fire[`CH_ZERO] |-> ch_val[`CH_ZERO] == $past(step_timer) || $past(shr || shl);
  endproperty
  a_capture_timer: assert property (p_capture_timer) else $error("target not overwritten"); // see [R3]

  property p_enable_gates;
    $past(!sim_zero_cross_enable) |-> !ch_fire[`CH_ZERO];
  endproperty
  a_enable_gates: assert property (p_enable_gates) else $error("zero fired while off"); // see [R2]

  property p_demag_in_order;
    ch_fire[`CH_DEMAG] |-> $past(phase) == motor_sim_pkg::PH_WAIT_D;
  endproperty
  a_demag_in_order: assert property (p_demag_in_order) else $error("demag out of order"); // see [R4]

  property p_sc_disarm;
    sc_rise && !wr_comm |=> !ch_armed[`CH_COMM] ##1 !ch_fire[`CH_COMM];
  endproperty
  a_sc_disarm: assert property (p_sc_disarm) else $error("comm armed without write"); // see [R11]

  property p_mult_ignored;
    sim_commutation_enable && !wr_comm && !ch_armed[`CH_COMM] |=> !ch_armed[`CH_COMM];
  endproperty
  a_mult_ignored: assert property (p_mult_ignored) else $error("multiplier armed comm"); // see [R7]

  property p_comm_restarts;
    ev_c |=> phase == motor_sim_pkg::PH_WAIT_D;
  endproperty
  a_comm_restarts: assert property (p_comm_restarts) else $error("comm did not restart"); // see [R8]

  property p_zero_resets;
    ev_z |=> step_timer == `REG_RST && evt_zero;
  endproperty
  a_zero_resets: assert property (p_zero_resets) else $error("timer kept after zero"); // see [R9]

  property p_one_per_arm;
    ch_fire[`CH_COMM] && !wr_comm && !hw_c_ok |=> !ch_fire[`CH_COMM];
  endproperty
  a_one_per_arm: assert property (p_one_per_arm) else $error("double commutation"); // see [R20]

  property p_plus_flag;
    shr |=> ratio_plus_flag;
  endproperty
  a_plus_flag: assert property (p_plus_flag) else $error("plus flag not set"); // see [R18]

endmodule : motor_sim_event_compare

// ### bench/motor_sim_event_compare_test.sv
// register-level bench of the simulated event compare block
`timescale 1ns/1ps
`include "motor_sim_map.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (a), (b)); end end
module motor_sim_event_compare_test;
  ////////////////////////////////////////////////////////////
  // stimulus and observed signals; only the stimulus and the check counters are defined at time zero
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic hw_demag = 1'b0;
  logic hw_zero = 1'b0;
  logic mult_load = 1'b0;
  logic [7:0] mult_value = 8'h01;
  logic evt_comm;
  logic evt_demag;
  logic evt_zero;
  logic [7:0] step_timer;
  logic [3:0] step_ratio_field;
  logic [7:0] rv;
  logic [7:0] t0;
  logic [7:0] d0;
  int fail_count = 0;
  int check_count = 0;
  int n;
  // tick of one clock keeps overflow runs short
  motor_sim_event_compare #(.TICK_CYCLES(1)) dut (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_demag(hw_demag),
    .hw_zero(hw_zero), .mult_load(mult_load), .mult_value(mult_value),
    .evt_comm(evt_comm), .evt_demag(evt_demag), .evt_zero(evt_zero),
    .step_timer(step_timer), .step_ratio_field(step_ratio_field));
  // 50 MHz clock
  initial begin
    forever #10 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////
  // verdict, printed once from here only
  task automatic tally_and_finish;
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
  // 0 hardware demag, 1 hardware zero crossing, 2 multiplier strobe
  task automatic pulse(input int s);
    @(posedge mclk);
    hw_demag <= (s == 0);
    hw_zero <= (s == 1);
    mult_load <= (s == 2);
    @(posedge mclk);
    {hw_demag, hw_zero, mult_load} <= 3'b000;
  endtask : pulse
  function automatic logic evt(input int s);
    return (s == 0) ? evt_demag : (s == 1) ? evt_zero : evt_comm;
  endfunction : evt
  // a missing event means the block has stalled, so the run stops here
  task automatic wait_evt(input int s, input int lim);
    check_count++;
    for (int i = 0; i < lim; i++) begin
      #1;
      if (evt(s) === 1'b1) begin
        return;
      end
      @(posedge mclk);
    end
    fail_count++;
    $display("wrong value at %0t: got %0h expected %0h", $time, 0, 1);
    tally_and_finish();
  endtask : wait_evt
  task automatic count_evt(input int s, input int lim, output int c);
    c = 0;
    repeat (lim) begin
      @(posedge mclk);
      #1;
      c += (evt(s) === 1'b1);
    end
  endtask : count_evt
  // cycles between two timer steps
  task automatic tick(output int c);
    logic [7:0] p;
    c = 0;
    // start after the caller's edge so a change made on that edge is not taken as a step
    @(posedge mclk);
    #1;
    p = step_timer;
    for (int i = 0; i < 50 && step_timer === p; i++) begin
      @(posedge mclk);
      #1;
    end
    p = step_timer;
    for (c = 1; c < 50; c++) begin
      @(posedge mclk);
      #1;
      if (step_timer !== p) begin
        break;
      end
    end
  endtask : tick
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge mclk);
    arst_n <= 1'b1;
    // reset contents, unmapped read, refused commutation write
    for (int a = 0; a < 6; a++) begin
      rd(a[3:0], rv);
      `CHK(rv, `REG_RST)
    end
    rd(`ADDR_STATUS, rv);
    `CHK(rv, 8'h04)
    rd(4'h9, rv);
    `CHK(rv, 8'h00)
    wr(`ADDR_COMM, 8'h40);
    rd(`ADDR_COMM, rv);
    `CHK(rv, 8'h00)
    // hardware order: demag before commutation is ignored
    pulse(0);
    count_evt(0, 6, n);
    `CHK(n, 0)
    pulse(2);
    wait_evt(2, 10);
    rd(`ADDR_STATUS, rv);
    `CHK(rv, 8'h08)
    wr(`ADDR_DEMAG, 8'h01);
    count_evt(0, 20, n);
    `CHK(n, 0)
    pulse(0);
    wait_evt(0, 10);
    pulse(1);
    wait_evt(1, 10);
    `CHK(step_timer < 8'h04, 1'b1)
    // simulated demag then simulated zero crossing in one step
    wr(`ADDR_CTRL_B, 8'h01);
    wr(`ADDR_CTRL_C, 8'h01);
    pulse(2);
    wait_evt(2, 10);
    t0 = step_timer + 8'h20;
    wr(`ADDR_DEMAG, t0);
    wait_evt(0, 60);
    rd(`ADDR_DEMAG, rv);
    `CHK(rv >= t0 && rv <= t0 + 8'h03, 1'b1)
    t0 = step_timer;
    wr(`ADDR_ZERO, 8'h01);
    wait_evt(1, 10);
    rd(`ADDR_ZERO, rv);
    `CHK(rv >= t0, 1'b1)
    count_evt(0, 30, n);
    `CHK(n, 0)
    wr(`ADDR_CTRL_B, 8'h00);
    // simulated commutation: multiplier ignored, write re-arms, repeats allowed
    wr(`ADDR_CTRL_C, 8'h02);
    pulse(2);
    count_evt(2, 20, n);
    `CHK(n, 0)
    wr(`ADDR_COMM, 8'h01);
    wait_evt(2, 10);
    rd(`ADDR_STATUS, rv);
    `CHK(rv, 8'h08)
    wr(`ADDR_COMM, 8'h01);
    wait_evt(2, 10);
    pulse(0);
    wait_evt(0, 10);
    pulse(1);
    wait_evt(1, 10);
    wr(`ADDR_CTRL_C, 8'h00);
    // tick period doubles with each ratio code
    tick(n);
    `CHK(n, 1)
    wr(`ADDR_PRESC, 8'h02);
    tick(n);
    `CHK(n, 4)
    `CHK(step_ratio_field, 4'h2)
    // the timer has just stepped and holds for four cycles, so a read sees this value
    t0 = step_timer;
    rd(`ADDR_TIMER, rv);
    `CHK(rv, t0)
    wr(`ADDR_PRESC, 8'h00);
    // auto mode overflow: ratio up, halve, plus flag, restart at median
    rd(`ADDR_DEMAG, d0);
    wr(`ADDR_CTRL_C, 8'h04);
    wr(`ADDR_PRESC, 8'h05);
    rd(`ADDR_PRESC, rv);
    `CHK(rv, 8'h00)
    for (int i = 0; i < 700 && step_ratio_field === 4'h0; i++) begin
      @(posedge mclk);
      #1;
    end
    `CHK(step_ratio_field, 4'h1)
    `CHK(step_timer >= `TIMER_MEDIAN && step_timer <= 8'h82, 1'b1)
    rd(`ADDR_STATUS, rv);
    `CHK(rv[`STAT_RPI], 1'b1)
    rd(`ADDR_DEMAG, rv);
    `CHK(rv, d0 >> 1)
    tick(n);
    `CHK(n, 2)
    wr(`ADDR_STATUS, 8'h01);
    rd(`ADDR_STATUS, rv);
    `CHK(rv[`STAT_RPI], 1'b0)
    // slow zero crossing keeps the ratio, a fast one lowers it
    pulse(2);
    wait_evt(2, 10);
    pulse(0);
    wait_evt(0, 10);
    pulse(1);
    wait_evt(1, 10);
    `CHK(step_ratio_field, 4'h1)
    pulse(2);
    wait_evt(2, 10);
    pulse(0);
    wait_evt(0, 10);
    rd(`ADDR_DEMAG, d0);
    pulse(1);
    wait_evt(1, 10);
    `CHK(step_ratio_field, 4'h0)
    rd(`ADDR_STATUS, rv);
    `CHK(rv[`STAT_RMI], 1'b1)
    rd(`ADDR_DEMAG, rv);
    `CHK(rv, (d0 >= 8'h80) ? 8'hFF : d0 << 1)
    tally_and_finish();
  end
endmodule : motor_sim_event_compare_test
